// [logic/monitor_cfg_pkg.sv]
/*
 Constants and carrier types for the monitor configuration and fault-flag logic.
 Assumes a 125 MHz system clock and an 8-bit register port driven by the serial slave.
*/
package monitor_cfg_pkg;
   localparam int unsigned CLOCK_MHZ = 125;
   localparam int unsigned PULSE_MS = 20;
   localparam int unsigned PULSE_CYCLES = PULSE_MS * 1000 * CLOCK_MHZ;
   localparam int unsigned PULSE_CW = 22;

   localparam logic [7:0] ADDR_CONFIG = 8'h40;
   localparam logic [7:0] ADDR_FLAGS_A = 8'h41;
   localparam logic [7:0] ADDR_FLAGS_B = 8'h42;
   localparam logic [7:0] ADDR_GATE_A = 8'h43;
   localparam logic [7:0] ADDR_GATE_B = 8'h44;
   localparam logic [7:0] ADDR_CHASSIS_CLR = 8'h46;
   localparam logic [7:0] ADDR_FAN_DIV = 8'h47;
   localparam logic [7:0] ADDR_TEMP_CFG = 8'h4B;

   localparam logic [7:0] CONFIG_RESET = 8'h08;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] GATE_RESET = 8'h00;
   localparam logic [7:0] CHASSIS_CLR_RESET = 8'h00;
   localparam logic [3:0] FAN_DIV_RESET = 4'h5;
   localparam logic [6:0] TEMP_CFG_RESET = 7'h01;

   localparam int unsigned CFG_START = 0;
   localparam int unsigned CFG_INT_EN = 1;
   localparam int unsigned CFG_RSVD_A = 2;
   localparam int unsigned CFG_RELEASE = 3;
   localparam int unsigned CFG_SYS_RESET = 4;
   localparam int unsigned CFG_RSVD_B = 5;
   localparam int unsigned CFG_INTRUSION = 6;
   localparam int unsigned CFG_INIT = 7;
   localparam int unsigned CHASSIS_CLR_BIT = 7;
   localparam int unsigned GATE_B_RESET_EN = 7;

   // Implemented flag bits: reserved status positions stay zero
   localparam logic [7:0] FLAGS_A_USED = 8'hDF;
   localparam logic [7:0] FLAGS_B_USED = 8'h13;
   localparam logic [7:0] CONFIG_WR_MASK = 8'hDB;

   // Register port: one access per strobe
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // Fault inputs from comparators and fan counters
   typedef struct packed {
      logic [7:0] flags_a;
      logic [7:0] flags_b;
   } fault_in_t;

   typedef struct packed {
      logic trigger;
      logic [PULSE_CW-1:0] count;
      logic active;
   } pulse_state_t;
endpackage

// [logic/monitor_config_interrupt_logic.sv]
/*
 Configuration, fault flag and fault gate registers of the hardware monitor, with the
 interrupt, system reset and intrusion pulse outputs.
 Assumes a serial slave that issues one-cycle read and write strobes with an 8-bit address,
 and comparator logic that raises one-cycle fault events per channel.
*/
// Summary of operation
// RULE1 - Config bit 0 runs the scan; zero holds standby; resets zero.
// RULE2 - Clearing the start bit never releases an asserted interrupt.
// RULE3 - Start bit set begins channel scanning and limit checks.
// RULE4 - Host programs all limits before setting the start bit.
// RULE5 - Config bit 1 enables the active-low interrupt output; resets zero.
// RULE6 - Config bit 3 releases interrupt, status registers untouched.
// RULE7 - Config bit 3 set suspends monitoring; resets to one.
// RULE8 - Config bit 4 gives 20 ms low reset pulse, self-clears when active.
// RULE9 - Reset pulse works only while second gate bit 7 is one.
// RULE10 - Config bit 6 gives 20 ms low intrusion pulse, like chassis clear.
// RULE11 - Config bit 7 restores defaults of listed registers, reads zero.
// RULE12 - Configuration resets to 08h; reserved bits 2 and 5 zero.
// RULE13 - First flags bits 0-3 mark voltage limit faults; reset 00h.
// RULE14 - First flags bit 4 marks temperature fault; bit 5 reserved.
// RULE15 - First flags bits 6 and 7 mark fan count faults.
// RULE16 - Second flags bits 0,1 mark 12 V and core B; reset 00h.
// RULE17 - Second flags bit 4 set when chassis intrusion input goes high.
// RULE18 - Reading a flag register clears the flags that read returned.
// RULE19 - An unserviced fault raises a fresh indication after the read.
// RULE20 - First gate bits block matching first flags from the interrupt.
// RULE21 - Second gate bits 0,1,4 block matching flags; reserved reset low.
// RULE22 - Host may gate an errant channel until the fault clears.
// RULE23 - Chassis clear bit clears itself after the pulse is output.
// RULE24 - Interrupt low when enabled, not released, and any ungated flag set.
`timescale 1ns/100ps
module monitor_config_interrupt_logic (
   input wire logic clock,
   input wire logic rst,
   input monitor_cfg_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input monitor_cfg_pkg::fault_in_t fault_in,
   input wire logic intrusion_in,
   output logic scan_enable,
   output logic [3:0] fan_divisor,
   output logic [6:0] temp_config,
   output logic int_n,
   output logic sys_reset_n,
   output logic intrusion_gate_n
);
   typedef struct packed {
      logic [7:0] config_r;
      logic [7:0] flags_a;
      logic [7:0] flags_b;
      logic [7:0] gate_a;
      logic [7:0] gate_b;
      logic [7:0] chassis_clr;
      logic [3:0] fan_div;
      logic [6:0] temp_cfg;
      logic [7:0] rdata;
      logic intrusion_prev;
      logic reset_fire;
      logic intrusion_fire;
      logic reset_busy;
      logic intrusion_busy;
      logic int_n;
      logic sys_reset_n;
      logic intrusion_gate_n;
      logic scan_enable;
   } state_t;

   state_t s_q, s_d;
   logic reset_active;
   logic intrusion_active;

   // Address match, used by the read mux and the write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction

   pulse_stretch #(
      .CYCLES(monitor_cfg_pkg::PULSE_CYCLES)
   ) reset_pulse (
      .clock(clock),
      .rst(rst),
      .trigger(s_q.reset_fire),
      .active(reset_active)
   );

   pulse_stretch #(
      .CYCLES(monitor_cfg_pkg::PULSE_CYCLES)
   ) intrusion_pulse (
      .clock(clock),
      .rst(rst),
      .trigger(s_q.intrusion_fire),
      .active(intrusion_active)
   );

   always_comb begin
      logic [7:0] clr_a;
      logic [7:0] clr_b;
      logic [7:0] ev_b;
      logic rd_a;
      logic rd_b;
      logic any_fault;
      logic init;
      clr_a = '0;
      init = 1'b0;
      clr_b = '0;
      ev_b = '0;
      rd_a = 1'b0;
      rd_b = 1'b0;
      any_fault = 1'b0;
      s_d = s_q;
      s_d.reset_fire = 1'b0;
      s_d.intrusion_fire = 1'b0;
      s_d.reset_busy = reset_active;
      s_d.intrusion_busy = intrusion_active;
      s_d.intrusion_prev = intrusion_in;

      // Read path; the returned flags are the ones cleared below
      rd_a = reg_req.rd && hit(reg_req.addr, monitor_cfg_pkg::ADDR_FLAGS_A);
      rd_b = reg_req.rd && hit(reg_req.addr, monitor_cfg_pkg::ADDR_FLAGS_B);
      if (reg_req.rd) begin
         if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_CONFIG)) begin
            s_d.rdata = s_q.config_r;
         end else if (rd_a) begin
            s_d.rdata = s_q.flags_a;
         end else if (rd_b) begin
            s_d.rdata = s_q.flags_b;
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_GATE_A)) begin
            s_d.rdata = s_q.gate_a;
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_GATE_B)) begin
            s_d.rdata = s_q.gate_b;
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_CHASSIS_CLR)) begin
            s_d.rdata = s_q.chassis_clr;
         end else begin
            s_d.rdata = 8'h00;
         end
      end
      if (rd_a) begin
         clr_a = s_q.flags_a; // RULE18
      end
      if (rd_b) begin
         clr_b = s_q.flags_b; // RULE18
      end

      // Events win over a clearing read, so an unserviced fault stays flagged
      ev_b[4] = intrusion_in && !s_q.intrusion_prev; // RULE17
      if (s_q.scan_enable) begin
         s_d.flags_a = ((s_q.flags_a & ~clr_a) | fault_in.flags_a)
                       & monitor_cfg_pkg::FLAGS_A_USED; // RULE13 RULE14 RULE15 RULE19
         s_d.flags_b = ((s_q.flags_b & ~clr_b) | fault_in.flags_b | ev_b)
                       & monitor_cfg_pkg::FLAGS_B_USED; // RULE16 RULE19
      end else begin
         s_d.flags_a = s_q.flags_a & ~clr_a;
         s_d.flags_b = ((s_q.flags_b & ~clr_b) | ev_b) & monitor_cfg_pkg::FLAGS_B_USED;
      end

      // Writes
      if (reg_req.wr) begin
         if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_CONFIG)) begin
            s_d.config_r = reg_req.wdata & monitor_cfg_pkg::CONFIG_WR_MASK; // RULE12
            // Applied on the write edge so a back-to-back read never sees bit 7 set
            if (reg_req.wdata[monitor_cfg_pkg::CFG_INIT]) begin
               init = 1'b1; // RULE11
            end
            if (reg_req.wdata[monitor_cfg_pkg::CFG_INTRUSION]) begin
               s_d.intrusion_fire = 1'b1; // RULE10
            end
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_GATE_A)) begin
            s_d.gate_a = reg_req.wdata; // RULE20
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_GATE_B)) begin
            s_d.gate_b = reg_req.wdata; // RULE21
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_CHASSIS_CLR)) begin
            s_d.chassis_clr = reg_req.wdata;
            if (reg_req.wdata[monitor_cfg_pkg::CHASSIS_CLR_BIT]) begin
               s_d.intrusion_fire = 1'b1; // RULE10
            end
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_FAN_DIV)) begin
            s_d.fan_div = reg_req.wdata[7:4];
         end else if (hit(reg_req.addr, monitor_cfg_pkg::ADDR_TEMP_CFG)) begin
            s_d.temp_cfg = reg_req.wdata[6:0];
         end
      end

      // System reset request: honoured only with the gate enable, bit drops once active
      if (s_q.config_r[monitor_cfg_pkg::CFG_SYS_RESET]) begin
         if (!s_q.gate_b[monitor_cfg_pkg::GATE_B_RESET_EN]) begin
            s_d.config_r[monitor_cfg_pkg::CFG_SYS_RESET] = 1'b0; // RULE9
         end else if (reset_active) begin
            s_d.config_r[monitor_cfg_pkg::CFG_SYS_RESET] = 1'b0; // RULE8
         end else if (!s_q.reset_busy) begin
            s_d.reset_fire = 1'b1; // RULE8 RULE9
         end
      end

      // Intrusion request bits drop when their pulse ends
      if (s_q.intrusion_busy && !intrusion_active) begin
         s_d.config_r[monitor_cfg_pkg::CFG_INTRUSION] = 1'b0; // RULE10
         s_d.chassis_clr[monitor_cfg_pkg::CHASSIS_CLR_BIT] = 1'b0; // RULE23
      end

      // Initialization restores defaults; the bit itself never sticks
      if (init) begin
         s_d.config_r = monitor_cfg_pkg::CONFIG_RESET; // RULE11
         s_d.flags_a = monitor_cfg_pkg::FLAGS_RESET;
         s_d.flags_b = monitor_cfg_pkg::FLAGS_RESET;
         s_d.gate_a = monitor_cfg_pkg::GATE_RESET;
         s_d.gate_b = monitor_cfg_pkg::GATE_RESET;
         s_d.fan_div = monitor_cfg_pkg::FAN_DIV_RESET;
         s_d.temp_cfg = monitor_cfg_pkg::TEMP_CFG_RESET;
      end

      // Scan runs on start, paused by the release bit; clearing start alone keeps int low
      s_d.scan_enable = s_d.config_r[monitor_cfg_pkg::CFG_START]
                        && !s_d.config_r[monitor_cfg_pkg::CFG_RELEASE]; // RULE1 RULE3 RULE7

      any_fault = |(s_d.flags_a & ~s_d.gate_a & monitor_cfg_pkg::FLAGS_A_USED)
                  || |(s_d.flags_b & ~s_d.gate_b & monitor_cfg_pkg::FLAGS_B_USED); // RULE20 RULE21
      s_d.int_n = !(s_d.config_r[monitor_cfg_pkg::CFG_INT_EN]
                    && !s_d.config_r[monitor_cfg_pkg::CFG_RELEASE]
                    && any_fault); // RULE2 RULE5 RULE6 RULE24
      s_d.sys_reset_n = !reset_active; // RULE8
      s_d.intrusion_gate_n = !intrusion_active; // RULE10
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
         s_q.config_r <= monitor_cfg_pkg::CONFIG_RESET; // RULE1 RULE7 RULE12
         s_q.flags_a <= monitor_cfg_pkg::FLAGS_RESET;
         s_q.flags_b <= monitor_cfg_pkg::FLAGS_RESET;
         s_q.gate_a <= monitor_cfg_pkg::GATE_RESET;
         s_q.gate_b <= monitor_cfg_pkg::GATE_RESET;
         s_q.chassis_clr <= monitor_cfg_pkg::CHASSIS_CLR_RESET;
         s_q.fan_div <= monitor_cfg_pkg::FAN_DIV_RESET;
         s_q.temp_cfg <= monitor_cfg_pkg::TEMP_CFG_RESET;
         s_q.int_n <= 1'b1;
         s_q.sys_reset_n <= 1'b1;
         s_q.intrusion_gate_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign scan_enable = s_q.scan_enable;
   assign fan_divisor = s_q.fan_div;
   assign temp_config = s_q.temp_cfg;
   assign int_n = s_q.int_n;
   assign sys_reset_n = s_q.sys_reset_n;
   assign intrusion_gate_n = s_q.intrusion_gate_n;
endmodule

// [logic/pulse_stretch.sv]
/*
 Stretches a one-cycle trigger into a pulse of a fixed number of clock cycles.
 Assumes the trigger is a single-cycle strobe; triggers during a pulse are absorbed.
*/
`timescale 1ns/100ps
module pulse_stretch #(
   parameter int unsigned CYCLES = monitor_cfg_pkg::PULSE_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic trigger,
   output logic active
);
   monitor_cfg_pkg::pulse_state_t st_q, st_d;

   always_comb begin
      st_d = st_q;
      st_d.trigger = trigger;
      if (st_q.active) begin
         if (st_q.count == monitor_cfg_pkg::PULSE_CW'(CYCLES - 1)) begin
            st_d.active = 1'b0;
            st_d.count = '0;
         end else begin
            st_d.count = st_q.count + 1'b1;
         end
      end else if (trigger) begin
         st_d.active = 1'b1;
         st_d.count = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign active = st_q.active;
endmodule

// [tb/host_model.sv]
/* Register host model issuing one-cycle read and write strobes.
 Assumes the block samples strobes on the rising clock edge. */
`timescale 1ns/100ps
module host_model (
   input wire logic clock,
   input wire logic [7:0] reg_rdata,
   output monitor_cfg_pkg::reg_req_t reg_req
);
   initial reg_req = '0;
   // Limits live outside; the bench also writes gates after the start bit
   // Callers may gate an errant channel before servicing it
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      reg_req.wr = w;
      reg_req.rd = !w;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(posedge clock);
      #1;
      // Idle fields scrambled so nothing leans on leftovers
      reg_req = {2'b00, ~a, ~d};
      @(posedge clock);
      #1;
      q = reg_rdata;
   endtask
endmodule

// [tb/monitor_cfg_chk.sv]
/* Port checker for the monitor config block.
 Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module monitor_cfg_chk (
   input wire logic clock,
   input wire logic rst,
   input monitor_cfg_pkg::reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input monitor_cfg_pkg::fault_in_t fault_in,
   input wire logic scan_enable,
   input wire logic int_n,
   input wire logic sys_reset_n,
   input wire logic intrusion_gate_n
);
   logic cw;
   logic [7:0] d;
   logic ok_q;
   logic arm_q;
   logic [7:0] ga_q;
   assign cw = reg_req.wr && reg_req.addr == 8'h40;
   assign d = reg_req.wdata;
   // Shadows of config and gates; an init write clears them too
   always_ff @(posedge clock) begin
      if (rst || (cw && d[7])) begin
         ok_q <= 1'b0;
         arm_q <= 1'b0;
         ga_q <= 8'h00;
      end else begin
         if (cw) ok_q <= d[1] && !d[3];
         if (reg_req.wr && reg_req.addr == 8'h43) ga_q <= d;
         if (reg_req.wr && reg_req.addr == 8'h44) arm_q <= d[7];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   reset_out_a: assert property (disable iff (1'b0) rst |=> int_n && sys_reset_n
      && intrusion_gate_n && !scan_enable && reg_rdata == 8'h00) else $error("bad reset state");
   cfg_rsvd_a: assert property (reg_req.rd && reg_req.addr == 8'h40 |=>
      !reg_rdata[7] && !reg_rdata[5] && !reg_rdata[2]) else $error("config bits not zero");
   start_scan_a: assert property (cw && d[0] && !d[3] && !d[7] |=> scan_enable)
      else $error("scan not started");
   release_int_a: assert property (cw && d[3] |=> int_n && !scan_enable)
      else $error("release failed");
   int_gate_a: assert property (!int_n |-> ok_q)
      else $error("interrupt while disabled");
   fault_int_a: assert property (!reg_req.wr && scan_enable && ok_q
      && |(fault_in.flags_a & ~ga_q & 8'hDF) |=> !int_n) else $error("fault missed");
   rst_pulse_a: assert property (cw && d[4] && !d[7] && arm_q && sys_reset_n
      |-> ##[2:6] !sys_reset_n) else $error("reset pulse missing");
   rst_refuse_a: assert property (cw && d[4] && !arm_q && sys_reset_n
      |=> sys_reset_n [*6]) else $error("reset pulse not gated");
   intr_pulse_a: assert property ((cw && d[6] || reg_req.wr && reg_req.addr == 8'h46
      && d[7]) && intrusion_gate_n |-> ##[2:5] !intrusion_gate_n) else $error("no pulse");
   cover property (!int_n);
   cover property ($fell(sys_reset_n));
   cover property ($fell(intrusion_gate_n));
endmodule
bind monitor_config_interrupt_logic monitor_cfg_chk chk (.clock(clock), .rst(rst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .fault_in(fault_in),
   .scan_enable(scan_enable), .int_n(int_n), .sys_reset_n(sys_reset_n),
   .intrusion_gate_n(intrusion_gate_n));

// [tb/monitor_config_interrupt_logic_bench.sv]
/* Self-checking bench for the monitor config block.
 Assumes host_model and the bound checker are compiled first. */
`timescale 1ns/100ps
module monitor_config_interrupt_logic_bench;
   logic clock = 1'b0;
   logic rst = 1'b1;
   monitor_cfg_pkg::reg_req_t reg_req;
   monitor_cfg_pkg::fault_in_t fault_in = '0;
   logic intrusion_in = 1'b0;
   logic [7:0] reg_rdata;
   logic scan_enable;
   logic int_n;
   logic sys_reset_n;
   logic intrusion_gate_n;
   logic [3:0] fan_divisor;
   logic [6:0] temp_config;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   always #4 clock = ~clock;
   monitor_config_interrupt_logic DUT (.clock(clock), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .fault_in(fault_in), .intrusion_in(intrusion_in),
      .scan_enable(scan_enable), .fan_divisor(fan_divisor), .temp_config(temp_config),
      .int_n(int_n),
      .sys_reset_n(sys_reset_n), .intrusion_gate_n(intrusion_gate_n));
   host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_req(reg_req));
   task automatic stop_test();
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.access(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      host.access(1'b0, a, 8'h00, q);
      check(q, exp);
   endtask
   // Order: scan, interrupt, reset pulse, intrusion pulse
   task automatic pins(input logic [3:0] exp);
      check({4'h0, scan_enable, int_n, sys_reset_n, intrusion_gate_n}, {4'h0, exp});
   endtask
   task automatic fault(input logic [7:0] a, input logic [7:0] b);
      fault_in = {a, b};
      @(posedge clock);
      #1;
      fault_in = '0;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Ceiling well above the roughly 110 cycles the sequence needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      step(2);
      rst = 1'b0;
      pins(4'h7);
      rd(8'h40, 8'h08);
      rd(8'h41, 8'h00);
      rd(8'h42, 8'h00);
      rd(8'h43, 8'h00);
      rd(8'h44, 8'h00);
      wr(8'h43, 8'hA5);
      rd(8'h43, 8'hA5);
      wr(8'h41, 8'hFF);
      rd(8'h41, 8'h00);
      wr(8'h43, 8'h00);
      wr(8'h40, 8'h27);
      rd(8'h40, 8'h03);
      pins(4'hF);
      fault(8'h01, 8'h00);
      pins(4'hB);
      rd(8'h41, 8'h01);
      pins(4'hF);
      rd(8'h41, 8'h00);
      // Fault still present during the read must come back
      fault(8'h40, 8'h00);
      fault_in = {8'h40, 8'h00};
      rd(8'h41, 8'h40);
      fault_in = '0;
      pins(4'hB);
      rd(8'h41, 8'h40);
      fault(8'h10, 8'h00);
      wr(8'h40, 8'h02);
      pins(4'h3);
      wr(8'h40, 8'h0B);
      pins(4'h7);
      rd(8'h41, 8'h10);
      fault(8'h80, 8'h00);
      rd(8'h41, 8'h00);
      wr(8'h40, 8'h03);
      wr(8'h43, 8'h01);
      fault(8'h01, 8'h00);
      pins(4'hF);
      rd(8'h41, 8'h01);
      wr(8'h44, 8'h13);
      intrusion_in = 1'b1;
      fault(8'h00, 8'h03);
      pins(4'hF);
      rd(8'h42, 8'h13);
      wr(8'h44, 8'h00);
      wr(8'h40, 8'h01);
      fault(8'h02, 8'h00);
      pins(4'hF);
      wr(8'h40, 8'h03);
      pins(4'hB);
      rd(8'h41, 8'h02);
      wr(8'h40, 8'h13);
      step(6);
      pins(4'hF);
      rd(8'h40, 8'h03);
      wr(8'h44, 8'h80);
      wr(8'h40, 8'h13);
      step(3);
      pins(4'hD);
      rd(8'h40, 8'h03);
      wr(8'h40, 8'h43);
      step(2);
      pins(4'hC);
      // Request bit must hold while the pulse is still being output
      wr(8'h46, 8'h81);
      rd(8'h46, 8'h81);
      wr(8'h47, 8'hF0);
      wr(8'h4B, 8'h7E);
      check({4'h0, fan_divisor}, 8'h0F);
      check({1'b0, temp_config}, 8'h7E);
      wr(8'h43, 8'hFF);
      wr(8'h40, 8'h80);
      rd(8'h40, 8'h08);
      rd(8'h43, 8'h00);
      rd(8'h44, 8'h00);
      check({4'h0, fan_divisor}, 8'h05);
      check({1'b0, temp_config}, 8'h01);
      stop_test();
   end
endmodule
